// file: inc/tppl_consts.svh
// Purpose: constants of the touch probe position latch
// Assumes: object-dictionary style register addresses
// Notes: included by its bare name
`ifndef TPPL_CONSTS_SVH
`define TPPL_CONSTS_SVH

// ----------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------
`define TPPL_ADDR_POLARITY 16'h2007
`define TPPL_SUB_POL_ONE 8'h00
`define TPPL_SUB_POL_TWO 8'h01
`define TPPL_ADDR_CTRL 16'h60B8
`define TPPL_ADDR_STATUS 16'h60B9
`define TPPL_ADDR_C1_RISE_POS 16'h60BA
`define TPPL_ADDR_C1_FALL_POS 16'h60BB
`define TPPL_ADDR_C2_RISE_POS 16'h60BC
`define TPPL_ADDR_C2_FALL_POS 16'h60BD
`define TPPL_ADDR_C1_RISE_CNT 16'h60D5
`define TPPL_ADDR_C1_FALL_CNT 16'h60D6
`define TPPL_ADDR_C2_RISE_CNT 16'h60D7
`define TPPL_ADDR_C2_FALL_CNT 16'h60D8

// ----------------------------------------------------------------
// field positions inside one channel byte, and the probe bits of the digital input status word
// ----------------------------------------------------------------
`define TPPL_CH_STRIDE 8
`define TPPL_CB_ENABLE 0
`define TPPL_CB_MODE 1
`define TPPL_CB_SOURCE 2
`define TPPL_CB_RISE 4
`define TPPL_CB_FALL 5
`define TPPL_SB_ENABLE 0
`define TPPL_SB_RISE 1
`define TPPL_SB_FALL 2
`define TPPL_CTRL_USED 8'h37
`define TPPL_DIN_EXT_ONE 26
`define TPPL_DIN_EXT_TWO 27

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define TPPL_RST_POL 16'h0001
`define TPPL_RST_CTRL 16'h0000

`endif

// file: inc/tppl_pkg.sv
// Purpose: types of the touch probe position latch
// Assumes: nothing
// Notes: constants live in tppl_consts.svh
package tppl_pkg;
    typedef enum logic [0:0] {
        TPPL_SINGLE = 1'b0,
        TPPL_CONTINUOUS = 1'b1
    } tppl_mode_type;
endpackage : tppl_pkg

// file: design/tppl_top.sv
// Purpose: two-channel touch probe position latch
// Assumes: probe and index inputs synchronous to clk_i
// Notes: single-cycle register port, reads are registered
`include "tppl_consts.svh"
`timescale 1ns/1ns
`default_nettype none

module tppl_top
    import tppl_pkg::*;
#(
    parameter int POS_W = 32,
    parameter int CNT_W = 32
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // register port
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [15:0] reg_addr_i,
    input wire logic [7:0] reg_sub_i,
    input wire logic [31:0] reg_wdata_i,
    output logic [31:0] reg_rdata_o,
    output logic reg_ack_o,
    // probe and feedback
    input wire logic external_probe_input_one_i,
    input wire logic external_probe_input_two_i,
    input wire logic index_pulse_i,
    input wire logic [POS_W-1:0] feedback_pos_i,
    // digital input status bits
    output logic [31:0] digital_input_status_o
);

    if (POS_W != 32 || CNT_W != 32) begin : g_bad_width
        $error("tppl_top supports only 32-bit position and count");
    end

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    logic [15:0] pol_one_q, pol_one_d;
    logic [15:0] pol_two_q, pol_two_d;
    logic [15:0] ctrl_q, ctrl_d;
    logic [31:0] rdata_q, rdata_d;
    logic ack_q, ack_d;
    logic [1:0] raw_q, raw_d;
    logic [31:0] din_q, din_d;
    logic ctrl_wr;
    logic [1:0] lvl;
    logic [15:0] status;
    logic [POS_W-1:0] rpos [2];
    logic [POS_W-1:0] fpos [2];
    logic [CNT_W-1:0] rcnt [2];
    logic [CNT_W-1:0] fcnt [2];
    logic [1:0] rflag, fflag, chen, rlatch, flatch;

    assign ctrl_wr = reg_wr_i && reg_addr_i == `TPPL_ADDR_CTRL;
    // polarity bit clear means inverted level
    assign lvl[0] = external_probe_input_one_i ^ ~pol_one_q[0];
    assign lvl[1] = external_probe_input_two_i ^ ~pol_two_q[0];

    // ------------------------------------------------------------
    // per-channel capture
    // ------------------------------------------------------------
    for (genvar c = 0; c < 2; c++) begin : g_ch
        localparam int B = c * `TPPL_CH_STRIDE;
        logic [7:0] cb, nb;
        logic trig, prev_q, prev_d;
        logic rf_q, rf_d, ff_q, ff_d;
        logic [POS_W-1:0] rp_q, rp_d, fp_q, fp_d;
        logic [CNT_W-1:0] rc_q, rc_d, fc_q, fc_d;
        logic rise, fall, rv, fv, reconf;
        tppl_mode_type mode;

        assign cb = ctrl_q[B+7:B];
        assign nb = reg_wdata_i[B+7:B];
        assign mode = tppl_mode_type'(cb[`TPPL_CB_MODE]);
        assign trig = cb[`TPPL_CB_SOURCE] ? index_pulse_i : lvl[c];
        assign rise = trig && !prev_q;
        assign fall = !trig && prev_q;
        assign reconf = ctrl_wr && ((cb & 8'h35) != (nb & 8'h35));
        assign rv = cb[`TPPL_CB_ENABLE] && cb[`TPPL_CB_RISE] && rise
                    && (mode == TPPL_CONTINUOUS || !rf_q);
        assign fv = cb[`TPPL_CB_ENABLE] && cb[`TPPL_CB_FALL] && fall
                    && mode == TPPL_CONTINUOUS;

        always_comb begin
            prev_d = trig;
            rf_d = rf_q;
            ff_d = ff_q;
            rp_d = rp_q;
            fp_d = fp_q;
            rc_d = rc_q;
            fc_d = fc_q;
            if (reconf) begin
                rf_d = 1'b0;
                ff_d = 1'b0;
                rc_d = '0;
                fc_d = '0;
            end else begin
                if (rv) begin
                    rf_d = 1'b1;
                    rp_d = feedback_pos_i;
                    rc_d = rc_q + 1'b1;
                end
                if (fv) begin
                    ff_d = 1'b1;
                    fp_d = feedback_pos_i;
                    fc_d = fc_q + 1'b1;
                end
            end
        end

        always_ff @(posedge clk_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
                prev_q <= 1'b0;
                rf_q <= 1'b0;
                ff_q <= 1'b0;
                rp_q <= '0;
                fp_q <= '0;
                rc_q <= '0;
                fc_q <= '0;
            end else begin
                prev_q <= prev_d;
                rf_q <= rf_d;
                ff_q <= ff_d;
                rp_q <= rp_d;
                fp_q <= fp_d;
                rc_q <= rc_d;
                fc_q <= fc_d;
            end
        end

        assign rflag[c] = rf_q;
        assign fflag[c] = ff_q;
        assign chen[c] = cb[`TPPL_CB_ENABLE];
        assign rlatch[c] = rv && !reconf;
        assign flatch[c] = fv && !reconf;
        assign rpos[c] = rp_q;
        assign fpos[c] = fp_q;
        assign rcnt[c] = rc_q;
        assign fcnt[c] = fc_q;
        assign status[B+7:B] = {5'b0_0000, ff_q, rf_q, chen[c]};

        property p_latch_takes_pos;
            @(posedge clk_i) disable iff (!rst_b_i)
            rlatch[c] |=> rp_q == $past(feedback_pos_i);
        endproperty
        a_latch_takes_pos: assert property (p_latch_takes_pos)
            else $error("rising latch lost position");
    end

    // ------------------------------------------------------------
    // register port
    // ------------------------------------------------------------
    always_comb begin
        pol_one_d = pol_one_q;
        pol_two_d = pol_two_q;
        ctrl_d = ctrl_q;
        ack_d = reg_wr_i || reg_rd_i;
        raw_d = {external_probe_input_two_i, external_probe_input_one_i};
        din_d = 32'h0000_0000;
        din_d[`TPPL_DIN_EXT_ONE] = raw_q[0];
        din_d[`TPPL_DIN_EXT_TWO] = raw_q[1];
        rdata_d = rdata_q;
        if (reg_wr_i && reg_addr_i == `TPPL_ADDR_POLARITY) begin
            if (reg_sub_i == `TPPL_SUB_POL_ONE) begin
                pol_one_d = reg_wdata_i[15:0];
            end else if (reg_sub_i == `TPPL_SUB_POL_TWO) begin
                pol_two_d = reg_wdata_i[15:0];
            end
        end
        if (ctrl_wr) begin
            ctrl_d = reg_wdata_i[15:0] & {`TPPL_CTRL_USED, `TPPL_CTRL_USED};
        end
        if (reg_rd_i) begin
            unique case (reg_addr_i)
                `TPPL_ADDR_POLARITY: rdata_d = {16'h0000,
                    reg_sub_i == `TPPL_SUB_POL_TWO ? pol_two_q : pol_one_q};
                `TPPL_ADDR_CTRL: rdata_d = {16'h0000, ctrl_q};
                `TPPL_ADDR_STATUS: rdata_d = {16'h0000, status};
                `TPPL_ADDR_C1_RISE_POS: rdata_d = rpos[0];
                `TPPL_ADDR_C1_FALL_POS: rdata_d = fpos[0];
                `TPPL_ADDR_C2_RISE_POS: rdata_d = rpos[1];
                `TPPL_ADDR_C2_FALL_POS: rdata_d = fpos[1];
                `TPPL_ADDR_C1_RISE_CNT: rdata_d = rcnt[0];
                `TPPL_ADDR_C1_FALL_CNT: rdata_d = fcnt[0];
                `TPPL_ADDR_C2_RISE_CNT: rdata_d = rcnt[1];
                `TPPL_ADDR_C2_FALL_CNT: rdata_d = fcnt[1];
                default: rdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pol_one_q <= `TPPL_RST_POL;
            pol_two_q <= `TPPL_RST_POL;
            ctrl_q <= `TPPL_RST_CTRL;
            rdata_q <= 32'h0000_0000;
            ack_q <= 1'b0;
            raw_q <= 2'b00;
            din_q <= 32'h0000_0000;
        end else begin
            pol_one_q <= pol_one_d;
            pol_two_q <= pol_two_d;
            ctrl_q <= ctrl_d;
            rdata_q <= rdata_d;
            ack_q <= ack_d;
            raw_q <= raw_d;
            din_q <= din_d;
        end
    end

    assign reg_rdata_o = rdata_q;
    assign reg_ack_o = ack_q;
    assign digital_input_status_o = din_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_rise_taken;
        rlatch[0] ##1 1'b1;
    endsequence

    property p_single_once;
        @(posedge clk_i) disable iff (!rst_b_i)
        (!ctrl_q[`TPPL_CB_MODE] && rflag[0] && !ctrl_wr) |-> !rlatch[0];
    endproperty
    a_single_once: assert property (p_single_once)
        else $error("single mode latched twice");

    property p_count_step;
        @(posedge clk_i) disable iff (!rst_b_i)
        s_rise_taken |-> rcnt[0] == $past(rcnt[0]) + 32'h0000_0001;
    endproperty
    a_count_step: assert property (p_count_step)
        else $error("rise counter did not step");

    property p_flag_after_latch;
        @(posedge clk_i) disable iff (!rst_b_i)
        rlatch[1] |=> rflag[1];
    endproperty
    a_flag_after_latch: assert property (p_flag_after_latch)
        else $error("rise flag not set");

    property p_fall_flag;
        @(posedge clk_i) disable iff (!rst_b_i)
        flatch[0] |=> fflag[0] && status[`TPPL_SB_FALL];
    endproperty
    a_fall_flag: assert property (p_fall_flag)
        else $error("fall flag not set");

    property p_no_fall_single;
        @(posedge clk_i) disable iff (!rst_b_i)
        !ctrl_q[`TPPL_CB_MODE] |-> !flatch[0];
    endproperty
    a_no_fall_single: assert property (p_no_fall_single)
        else $error("falling latch in single mode");

    property p_reconf_clears;
        @(posedge clk_i) disable iff (!rst_b_i)
        (ctrl_wr && reg_wdata_i[0] != ctrl_q[0]) |=> rcnt[0] == 0 && !rflag[0];
    endproperty
    a_reconf_clears: assert property (p_reconf_clears)
        else $error("reconfigure did not clear channel");

    property p_status_enable;
        @(posedge clk_i) disable iff (!rst_b_i)
        status[`TPPL_CH_STRIDE] == ctrl_q[`TPPL_CH_STRIDE];
    endproperty
    a_status_enable: assert property (p_status_enable)
        else $error("status enable mismatch");

    property p_reserved_zero;
        @(posedge clk_i) disable iff (!rst_b_i)
        status[7:3] == 5'h00 && status[15:11] == 5'h00 && ctrl_q[3] == 1'b0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved bit nonzero");

    property p_din_mirror;
        @(posedge clk_i) disable iff (!rst_b_i)
        1'b1 ##2 din_q[`TPPL_DIN_EXT_ONE] == $past(external_probe_input_one_i, 2);
    endproperty
    a_din_mirror: assert property (p_din_mirror)
        else $error("probe level not mirrored");

    property p_fall_two;
        @(posedge clk_i) disable iff (!rst_b_i)
        flatch[1] |=> fflag[1] && fpos[1] == $past(feedback_pos_i)
            && fcnt[1] == $past(fcnt[1]) + 32'h0000_0001;
    endproperty
    a_fall_two: assert property (p_fall_two)
        else $error("channel two falling latch lost value");

endmodule : tppl_top

`default_nettype wire

// file: bench/tppl_probe_model.sv
// Purpose: probe switch, second probe and encoder index model
// Assumes: lines change 1 ns after the rising edge of clk_i
// Notes: all three lines rest low between pulses
`timescale 1ns/1ns
`default_nettype none

module tppl_probe_model (
    // clock
    input wire logic clk_i,
    // probe and index lines
    output logic probe_one_o,
    output logic probe_two_o,
    output logic index_o
);
    initial begin
        probe_one_o = 1'b0;
        probe_two_o = 1'b0;
        index_o = 1'b0;
    end

    // ----------------------------------------------------------------
    // line drivers: sel 0 probe one, 1 probe two, 2 index
    // ----------------------------------------------------------------
    task automatic set_line(input int sel, input logic v, input int w);
        @(posedge clk_i);
        #1;
        case (sel)
            0: probe_one_o = v;
            1: probe_two_o = v;
            default: index_o = v;
        endcase
        repeat (w) @(posedge clk_i);
    endtask : set_line

    task automatic pulse(input int sel, input int w);
        set_line(sel, 1'b1, w);
        set_line(sel, 1'b0, w);
    endtask : pulse
endmodule : tppl_probe_model

`default_nettype wire

// file: bench/tb_top.sv
// Purpose: self-checking bench of the touch probe position latch
// Assumes: register port strobes last one cycle, driven 1 ns after edge
// Notes: expectations come from the control and status bit layout
`include "tppl_consts.svh"
`timescale 1ns/1ns
`default_nettype none

module tb_top;
    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [15:0] reg_addr_i = 16'h0000;
    logic [7:0] reg_sub_i = 8'h00;
    logic [31:0] reg_wdata_i = 32'h0000_0000;
    logic [31:0] fb = 32'h0000_0000;
    logic [31:0] reg_rdata_o;
    logic [31:0] din_o;
    logic reg_ack_o;
    logic p1;
    logic p2;
    logic idx;
    int n_errors = 0;
    int check_count = 0;

    always #4 clk_i = ~clk_i;

    tppl_probe_model pm (.clk_i(clk_i), .probe_one_o(p1),
        .probe_two_o(p2), .index_o(idx));

    tppl_top DUT (.clk_i(clk_i), .rst_b_i(rst_b_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
        .reg_sub_i(reg_sub_i), .reg_wdata_i(reg_wdata_i),
        .reg_rdata_o(reg_rdata_o), .reg_ack_o(reg_ack_o),
        .external_probe_input_one_i(p1), .external_probe_input_two_i(p2),
        .index_pulse_i(idx), .feedback_pos_i(fb),
        .digital_input_status_o(din_o));

    // ----------------------------------------------------------------
    // register access and comparison
    // ----------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic acc(input logic w, input logic [15:0] a,
                       input logic [7:0] s, input logic [31:0] d);
        @(posedge clk_i);
        #1;
        reg_wr_i = w;
        reg_rd_i = ~w;
        reg_addr_i = a;
        reg_sub_i = s;
        reg_wdata_i = d;
        @(posedge clk_i);
        #1;
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        chk("ack", 32'h0000_0001, {31'h0, reg_ack_o});
    endtask : acc

    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        acc(1'b1, a, 8'h00, d);
    endtask : wr

    task automatic rd(input string nm, input logic [15:0] a,
                      input logic [31:0] e);
        acc(1'b0, a, 8'h00, 32'h0000_0000);
        chk(nm, e, reg_rdata_o);
    endtask : rd

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        logic [15:0] tab [10] = '{`TPPL_ADDR_CTRL, `TPPL_ADDR_STATUS,
            `TPPL_ADDR_C1_RISE_POS, `TPPL_ADDR_C1_FALL_POS,
            `TPPL_ADDR_C2_RISE_POS, `TPPL_ADDR_C2_FALL_POS,
            `TPPL_ADDR_C1_RISE_CNT, `TPPL_ADDR_C1_FALL_CNT,
            `TPPL_ADDR_C2_RISE_CNT, `TPPL_ADDR_C2_FALL_CNT};
        foreach (tab[i]) rd("reset value", tab[i], 32'h0000_0000);
        rd("pol one", `TPPL_ADDR_POLARITY, 32'h0000_0001);
        acc(1'b0, `TPPL_ADDR_POLARITY, 8'h01, 32'h0000_0000);
        chk("pol two", 32'h0000_0001, reg_rdata_o);
        rd("unmapped", 16'h1234, 32'h0000_0000);
        wr(`TPPL_ADDR_C1_RISE_POS, 32'h0000_5555);
        rd("ro write", `TPPL_ADDR_C1_RISE_POS, 32'h0000_0000);
    endtask : t_reset

    task automatic t_single();
        fb = 32'h0000_0064;
        wr(`TPPL_ADDR_CTRL, 32'h0000_0031);
        rd("enabled", `TPPL_ADDR_STATUS, 32'h0000_0001);
        pm.pulse(0, 3);
        rd("rise pos", `TPPL_ADDR_C1_RISE_POS, 32'h0000_0064);
        rd("rise flag", `TPPL_ADDR_STATUS, 32'h0000_0003);
        rd("no fall", `TPPL_ADDR_C1_FALL_CNT, 32'h0000_0000);
        fb = 32'h0000_00C8;
        pm.pulse(0, 3);
        rd("held pos", `TPPL_ADDR_C1_RISE_POS, 32'h0000_0064);
        rd("one count", `TPPL_ADDR_C1_RISE_CNT, 32'h0000_0001);
        wr(`TPPL_ADDR_CTRL, 32'h0000_0030);
        rd("cleared", `TPPL_ADDR_STATUS, 32'h0000_0000);
        rd("cnt clear", `TPPL_ADDR_C1_RISE_CNT, 32'h0000_0000);
        wr(`TPPL_ADDR_CTRL, 32'h0000_0031);
        pm.pulse(0, 3);
        rd("rearmed", `TPPL_ADDR_C1_RISE_POS, 32'h0000_00C8);
    endtask : t_single

    task automatic t_cont();
        fb = 32'hFFFF_FF00;
        wr(`TPPL_ADDR_CTRL, 32'h0000_3700);
        pm.pulse(1, 3);
        pm.set_line(2, 1'b1, 3);
        #1 fb = 32'h0000_0500;
        pm.set_line(2, 1'b0, 3);
        #1 fb = 32'h8000_0001;
        pm.pulse(2, 3);
        rd("c2 rise", `TPPL_ADDR_C2_RISE_POS, 32'h8000_0001);
        rd("c2 fall", `TPPL_ADDR_C2_FALL_POS, 32'h8000_0001);
        rd("c2 rcnt", `TPPL_ADDR_C2_RISE_CNT, 32'h0000_0002);
        rd("c2 fcnt", `TPPL_ADDR_C2_FALL_CNT, 32'h0000_0002);
        rd("c2 stat", `TPPL_ADDR_STATUS, 32'h0000_0700);
        rd("c1 idle", `TPPL_ADDR_C1_RISE_CNT, 32'h0000_0000);
    endtask : t_cont

    task automatic t_polarity();
        wr(`TPPL_ADDR_CTRL, 32'h0000_0000);
        acc(1'b1, `TPPL_ADDR_POLARITY, 8'h00, 32'h0000_0000);
        wr(`TPPL_ADDR_CTRL, 32'h0000_0033);
        fb = 32'h0000_0777;
        pm.set_line(0, 1'b1, 3);
        #1;
        chk("mirror one", 32'h0400_0000, din_o);
        rd("inv fall", `TPPL_ADDR_C1_FALL_POS, 32'h0000_0777);
        rd("inv stat", `TPPL_ADDR_STATUS, 32'h0000_0005);
        rd("inv rcnt", `TPPL_ADDR_C1_RISE_CNT, 32'h0000_0000);
        pm.set_line(1, 1'b1, 3);
        #1;
        chk("mirror two", 32'h0C00_0000, din_o);
        acc(1'b1, `TPPL_ADDR_POLARITY, 8'h01, 32'h0000_0000);
        wr(`TPPL_ADDR_CTRL, 32'h0000_3300);
        fb = 32'h0000_0999;
        pm.set_line(1, 1'b0, 3);
        rd("inv two rise", `TPPL_ADDR_C2_RISE_POS, 32'h0000_0999);
        rd("inv two fcnt", `TPPL_ADDR_C2_FALL_CNT, 32'h0000_0000);
    endtask : t_polarity

    task automatic t_reserved();
        wr(`TPPL_ADDR_CTRL, 32'h0000_FFFF);
        rd("reserved", `TPPL_ADDR_CTRL, 32'h0000_3737);
    endtask : t_reserved

    // ----------------------------------------------------------------
    // run control
    // ----------------------------------------------------------------
    task automatic report_and_stop();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        repeat (8) @(posedge clk_i);
        #1 rst_b_i = 1'b1;
        t_reset();
        t_single();
        t_cont();
        t_polarity();
        t_reserved();
        report_and_stop();
    end

    initial begin
        #100000;
        n_errors++;
        report_and_stop();
    end
endmodule : tb_top

`default_nettype wire
